/* File: hw/srw_supervisor.sv */
// Purpose: power-on reset, undervoltage reset and watchdog for an external controller
// Assumes: supply comparator (with hysteresis) gives a logic level, pins asynchronous
// Notes:   reset line is open drain; only the output enable is ever asserted
// What this block does
// - after the supply first reaches threshold, reset stays low for the power-on delay, then releases.
// - a supply dip longer than the reaction time pulls reset low; shorter dips are ignored, except during the power-on delay, which any dip restarts.
// - the reset output is open drain active low, pulling low or releasing, never driving high.
// - the watchdog is disabled while the enable input is low.
// - the watchdog is enabled when the enable input is high or open, open reading high via pull-up.
// - each valid falling trigger edge before expiry restarts the watchdog period.
// - the trigger is sampled every sample period and two high then two low samples form a trigger.
// - a period without a valid trigger gives a reset pulse of the watchdog reset time.
// - reset and watchdog events drive only the reset output, nothing else.
`timescale 1ns/1ps
`default_nettype none
module srw_supervisor #(
    parameter int unsigned POR_TICKS  = srw_pkg::POR_DELAY_US,
    parameter int unsigned RR_TICKS   = srw_pkg::REACTION_US,
    parameter int unsigned SAM_TICKS  = srw_pkg::SAMPLE_US,
    parameter int unsigned WDP_TICKS  = srw_pkg::WD_PERIOD_US,
    parameter int unsigned WDR_TICKS  = srw_pkg::WD_RESET_US,
    parameter int unsigned TICK_CYC   = srw_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic resetn,
    // supply comparator: high while supply above threshold
    input  wire logic supply_above_threshold,
    // watchdog pins
    input  wire logic wd_trigger_in,
    input  wire logic wd_enable_in,
    // open-drain reset line: output value and enable
    output logic      reset_out_n_o,
    output logic      reset_out_n_oe
);
    // elaboration checks against counter widths
    if (POR_TICKS < 1 || POR_TICKS > 131071 || WDP_TICKS < 1 || WDP_TICKS > 131071 ||
        WDR_TICKS < 1 || WDR_TICKS > 131071 || RR_TICKS < 1 || RR_TICKS > 15 ||
        SAM_TICKS < 1 || SAM_TICKS > 127 ||
        TICK_CYC < 1 || TICK_CYC > 1023) begin : g_bad
        $error("srw_supervisor: parameter out of range");
    end

    srw_pkg::srw_state_t s_q;
    srw_pkg::srw_state_t s_d;

    logic tick;
    logic sup_ok;
    logic wd_on;
    logic sample_now;
    logic trig_valid;

    // agreed pin levels and time base strobes
    always_comb begin
        tick       = (s_q.pre == 10'(TICK_CYC - 1));
        sup_ok     = s_q.sync.supply_lvl;
        wd_on      = s_q.sync.wd_en_lvl;
        sample_now = tick && (s_q.samp == 7'(SAM_TICKS - 1));
        trig_valid = sample_now && (s_q.hist[2:0] == 3'b110) && !s_q.sync.trig_lvl;
    end

    // next state
    always_comb begin
        s_d = s_q;
        s_d.sync.supply_ok = {s_q.sync.supply_ok[1:0], supply_above_threshold};
        s_d.sync.trig      = {s_q.sync.trig[1:0], wd_trigger_in};
        s_d.sync.wd_en     = {s_q.sync.wd_en[1:0], wd_enable_in};
        // a level moves only once second and third stages agree
        if (s_q.sync.supply_ok[1] == s_q.sync.supply_ok[2]) begin
            s_d.sync.supply_lvl = s_q.sync.supply_ok[2];
        end
        if (s_q.sync.trig[1] == s_q.sync.trig[2]) begin
            s_d.sync.trig_lvl = s_q.sync.trig[2];
        end
        if (s_q.sync.wd_en[1] == s_q.sync.wd_en[2]) begin
            s_d.sync.wd_en_lvl = s_q.sync.wd_en[2];
        end
        // time base prescaler
        s_d.pre = tick ? 10'h000 : s_q.pre + 10'h001;
        // dip filter, counts ticks below threshold
        if (sup_ok) begin
            s_d.dip = 4'h0;
        end else if (tick && s_q.dip != 4'hf) begin
            s_d.dip = s_q.dip + 4'h1;
        end
        unique case (s_q.phase)
            srw_pkg::SRW_POWER_DOWN: begin
                s_d.rst_oe = 1'b1;
                s_d.tmr    = 17'h00000;
                if (sup_ok) begin
                    s_d.phase = srw_pkg::SRW_POR_DELAY;
                end
            end
            srw_pkg::SRW_POR_DELAY: begin
                s_d.rst_oe = 1'b1;
                if (!sup_ok) begin
                    s_d.phase = srw_pkg::SRW_POWER_DOWN;
                end else if (tick) begin
                    if (s_q.tmr == 17'(POR_TICKS - 1)) begin
                        s_d.phase  = srw_pkg::SRW_RUN;
                        s_d.rst_oe = 1'b0;
                        s_d.tmr    = 17'h00000;
                        s_d.samp   = 7'h00;
                        s_d.hist   = 4'h0;
                    end else begin
                        s_d.tmr = s_q.tmr + 17'h00001;
                    end
                end
            end
            srw_pkg::SRW_RUN: begin
                s_d.rst_oe = 1'b0;
                if (sample_now) begin
                    s_d.samp = 7'h00;
                    s_d.hist = {s_q.hist[2:0], s_q.sync.trig_lvl};
                end else if (tick) begin
                    s_d.samp = s_q.samp + 7'h01;
                end
                if (!wd_on || trig_valid) begin
                    s_d.tmr = 17'h00000;
                end else if (tick) begin
                    if (s_q.tmr == 17'(WDP_TICKS - 1)) begin
                        s_d.phase  = srw_pkg::SRW_WD_RESET;
                        s_d.rst_oe = 1'b1;
                        s_d.tmr    = 17'h00000;
                    end else begin
                        s_d.tmr = s_q.tmr + 17'h00001;
                    end
                end
            end
            srw_pkg::SRW_WD_RESET: begin
                s_d.rst_oe = 1'b1;
                if (tick) begin
                    if (s_q.tmr == 17'(WDR_TICKS - 1)) begin
                        s_d.phase  = srw_pkg::SRW_RUN;
                        s_d.rst_oe = 1'b0;
                        s_d.tmr    = 17'h00000;
                        s_d.samp   = 7'h00;
                        s_d.hist   = 4'h0;
                    end else begin
                        s_d.tmr = s_q.tmr + 17'h00001;
                    end
                end
            end
        endcase
        // undervoltage longer than reaction time overrides all
        if (tick && s_q.dip >= 4'(RR_TICKS) && !sup_ok) begin
            s_d.phase  = srw_pkg::SRW_POWER_DOWN;
            s_d.rst_oe = 1'b1;
            s_d.tmr    = 17'h00000;
        end
    end

    // state register
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_q        <= '0;
            s_q.phase  <= srw_pkg::SRW_POWER_DOWN;
            s_q.rst_oe <= srw_pkg::RST_OE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // open drain: value always low, only the enable moves
    assign reset_out_n_o  = 1'b0;
    assign reset_out_n_oe = s_q.rst_oe;

    property p_never_high;
        @(posedge clock) disable iff (!resetn) reset_out_n_o == 1'b0;
    endproperty
    a_never_high: assert property (p_never_high) else $error("reset line driven high");

    property p_run_released;
        @(posedge clock) disable iff (!resetn) (s_q.phase == srw_pkg::SRW_RUN) |-> !reset_out_n_oe;
    endproperty
    a_run_released: assert property (p_run_released) else $error("reset asserted while running");

    property p_por_release;
        @(posedge clock) disable iff (!resetn)
            (s_q.phase == srw_pkg::SRW_POR_DELAY && $past(s_q.phase) == srw_pkg::SRW_POWER_DOWN)
            |-> reset_out_n_oe [*8];
    endproperty
    a_por_release: assert property (p_por_release) else $error("power-on delay released early");

    property p_dip;
        @(posedge clock) disable iff (!resetn)
            (tick && !sup_ok && s_q.dip >= 4'(RR_TICKS)) |=> reset_out_n_oe;
    endproperty
    a_dip: assert property (p_dip) else $error("long dip did not reset");

    property p_disabled;
        @(posedge clock) disable iff (!resetn)
            (s_q.phase == srw_pkg::SRW_RUN && !wd_on) |=> (s_q.tmr == 17'h00000);
    endproperty
    a_disabled: assert property (p_disabled) else $error("watchdog ran while disabled");

    property p_enabled_runs;
        @(posedge clock) disable iff (!resetn)
            (s_q.phase == srw_pkg::SRW_RUN && wd_on && tick && !trig_valid && s_q.tmr == 17'h00000
             && sup_ok && s_q.dip == 4'h0) |=> (s_q.tmr == 17'h00001);
    endproperty
    a_enabled_runs: assert property (p_enabled_runs) else $error("enabled watchdog not counting");

    property p_retrigger;
        @(posedge clock) disable iff (!resetn)
            (s_q.phase == srw_pkg::SRW_RUN && trig_valid && sup_ok) |=> (s_q.tmr == 17'h00000);
    endproperty
    a_retrigger: assert property (p_retrigger) else $error("valid trigger did not restart");

    property p_pattern;
        @(posedge clock) disable iff (!resetn)
            trig_valid |-> (sample_now && s_q.hist[2:1] == 2'b11 && !s_q.hist[0]);
    endproperty
    a_pattern: assert property (p_pattern) else $error("trigger without two high two low");

    // each sample instant in RUN must shift the agreed pin level into the history
    property p_hist_shift;
        @(posedge clock) disable iff (!resetn)
            (s_q.phase == srw_pkg::SRW_RUN && sample_now) |=> (s_q.hist[0] == $past(s_q.sync.trig_lvl));
    endproperty
    a_hist_shift: assert property (p_hist_shift) else $error("trigger sample not recorded");

    property p_expire;
        @(posedge clock) disable iff (!resetn)
            (s_q.phase == srw_pkg::SRW_RUN && wd_on && tick && !trig_valid && sup_ok
             && s_q.tmr == 17'(WDP_TICKS - 1)) |=> (reset_out_n_oe && s_q.phase == srw_pkg::SRW_WD_RESET);
    endproperty
    a_expire: assert property (p_expire) else $error("missed period gave no reset");

    property p_fresh;
        @(posedge clock) disable iff (!resetn)
            ($fell(reset_out_n_oe)) |-> (s_q.tmr == 17'h00000 && s_q.hist == 4'h0 && s_q.samp == 7'h00);
    endproperty
    a_fresh: assert property (p_fresh) else $error("release without fresh period");

endmodule : srw_supervisor
`default_nettype wire

/* File: hw/srw_pkg.sv */
// Purpose: constants and carrier types for the supply reset and watchdog supervisor
// Assumes: 125 MHz system clock, internal time base tick derived from it
// Notes:   times kept in their own unit, cycle counts derived from them
package srw_pkg;
    // system clock
    localparam int unsigned CLK_PERIOD_NS   = 8;
    // internal time base tick of 1 us
    localparam int unsigned TICK_NS         = 1000;
    localparam int unsigned TICK_CYCLES     = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // times in time-base ticks (microseconds)
    localparam int unsigned POR_DELAY_US    = 15000;
    localparam int unsigned REACTION_US     = 4;
    localparam int unsigned SAMPLE_US       = 64;
    localparam int unsigned WD_PERIOD_US    = 60000;
    localparam int unsigned WD_RESET_US     = 240;
    // reset value of the reset line output enable: pulling low
    localparam logic        RST_OE_RESET    = 1'b1;

    // supervisor phases
    typedef enum logic [1:0] {
        SRW_POWER_DOWN,
        SRW_POR_DELAY,
        SRW_RUN,
        SRW_WD_RESET
    } srw_phase_t;

    // synchronised pin levels
    typedef struct packed {
        logic [2:0] supply_ok;
        logic [2:0] trig;
        logic [2:0] wd_en;
        logic       supply_lvl;
        logic       trig_lvl;
        logic       wd_en_lvl;
    } srw_sync_t;

    // whole supervisor state
    typedef struct packed {
        srw_sync_t  sync;
        srw_phase_t phase;
        logic [9:0]  pre;
        logic [16:0] tmr;
        logic [3:0]  dip;
        logic [6:0]  samp;
        logic [3:0]  hist;
        logic [1:0]  hcnt;
        logic        rst_oe;
    } srw_state_t;
endpackage : srw_pkg

/* File: verif/srw_mcu_model.sv */
// Purpose: controller on the far side of the supervised reset line
// Assumes: reset line already resolved with its pull-up by the bench
// Notes:   mode 0 holds trigger high, 1 toggles, 2 gives one-cycle low glitches
`timescale 1ns/1ps
`default_nettype none
module srw_mcu_model (
    // clock and reset line as seen by the controller
    input  wire logic       clock,
    input  wire logic       line_n,
    // trigger behaviour
    input  wire logic [1:0] mode,
    input  wire logic [7:0] half_len,
    // trigger pin
    output logic            trig
);
    logic [7:0] cnt;
    initial begin
        trig = 1'b1;
        cnt  = 8'h00;
    end
    // controller runs only while the line is released high
    always @(posedge clock) begin
        if (line_n !== 1'b1 || mode == 2'h0) begin
            cnt  <= 8'h00;
            trig <= 1'b1;
        end else if (cnt >= half_len) begin
            cnt  <= 8'h00;
            trig <= (mode == 2'h1) ? ~trig : 1'b0;
        end else begin
            cnt <= cnt + 8'h01;
            if (mode == 2'h2) trig <= 1'b1;
        end
    end
endmodule // srw_mcu_model
`default_nettype wire

/* File: verif/tb_top.sv */
// Purpose: self-checking bench for the supply reset and watchdog supervisor
// Assumes: short timing parameters, tick of two clock cycles
// Notes:   reset line resolved here from the open-drain enable and a pull-up
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int TK = 2, POR = 20, SAM = 2, WDP = 100, WDR = 5, RR = 2;
    logic       clock = 1'b0, resetn = 1'b0, supply = 1'b1, en = 1'b1;
    logic       trig, rst_o, rst_oe, line_n;
    logic       en_open = 1'b0;
    // enable pin with its pull-up, left open when en_open is set
    tri1        en_pin;
    assign en_pin = en_open ? 1'bz : en;
    logic [1:0] mode = 2'h0;
    logic [7:0] half = 8'h10;
    int         err_count = 0, cmp_count = 0, n;
    // clock and pulled-up reset line
    always #4 clock = ~clock;
    assign line_n = rst_oe ? 1'b0 : 1'b1;
    srw_supervisor #(.POR_TICKS(POR), .RR_TICKS(RR), .SAM_TICKS(SAM), .WDP_TICKS(WDP),
        .WDR_TICKS(WDR), .TICK_CYC(TK)) uut (.clock(clock), .resetn(resetn),
        .supply_above_threshold(supply), .wd_trigger_in(trig), .wd_enable_in(en_pin),
        .reset_out_n_o(rst_o), .reset_out_n_oe(rst_oe));
    srw_mcu_model mcu (.clock(clock), .line_n(line_n), .mode(mode), .half_len(half), .trig(trig));
    task automatic chk(input bit ok, input string msg);
        cmp_count++;
        if (!ok) begin
            err_count++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask
    // cycles until the enable reaches v, bounded by lim
    task automatic wait_oe(input logic v, input int lim, output int c);
        c = 0;
        while (rst_oe !== v && c < lim) begin
            @(posedge clock);
            #1;
            c++;
        end
    endtask
    // pull-down only, never a driven high
    always @(posedge clock) if (resetn) chk(rst_o === 1'b0, "line driven high");
    task automatic t_por;
        wait_oe(1'b0, 200, n);
        chk(n >= POR*TK && n <= POR*TK+12, "power-on delay");
        chk(line_n === 1'b1, "line not released");
    endtask
    task automatic t_expire;
        repeat (2) begin
            wait_oe(1'b1, 400, n);
            chk(n >= WDP*TK-4 && n <= WDP*TK+8, "watchdog period");
            wait_oe(1'b0, 100, n);
            chk(n >= WDR*TK-2 && n <= WDR*TK+4, "watchdog pulse");
        end
    endtask
    task automatic t_kick;
        @(posedge clock) mode <= 2'h1;
        wait_oe(1'b1, 3*WDP*TK, n);
        chk(n == 3*WDP*TK, "reset despite triggers");
    endtask
    task automatic t_glitch;
        @(posedge clock) begin
            mode <= 2'h2;
            half <= 8'h07;
        end
        wait_oe(1'b1, WDP*TK+20, n);
        chk(n <= WDP*TK+8, "glitch taken as trigger");
        wait_oe(1'b0, 100, n);
    endtask
    task automatic t_disable;
        @(posedge clock) begin
            en   <= 1'b0;
            mode <= 2'h0;
        end
        wait_oe(1'b1, 3*WDP*TK, n);
        chk(n == 3*WDP*TK, "reset while disabled");
        // pin left open: the pull-up must enable the watchdog
        @(posedge clock) en_open <= 1'b1;
        wait_oe(1'b1, 400, n);
        chk(n >= WDP*TK-4 && n <= WDP*TK+10, "period after enable");
        wait_oe(1'b0, 100, n);
    endtask
    task automatic t_dip;
        @(posedge clock) begin
            mode <= 2'h1;
            half <= 8'h10;
            supply <= 1'b0;
        end
        repeat (2) @(posedge clock);
        supply <= 1'b1;
        wait_oe(1'b1, 40, n);
        chk(n == 40, "short dip gave reset");
        @(posedge clock) supply <= 1'b0;
        wait_oe(1'b1, RR*TK+12, n);
        chk(n >= RR*TK && n <= RR*TK+8, "dip reaction");
        @(posedge clock) supply <= 1'b1;
        wait_oe(1'b0, POR*TK+20, n);
        chk(n >= POR*TK && n <= POR*TK+14, "delay after dip");
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // watchdog against a hang, far beyond the expected run
    initial begin
        #(8*8000);
        err_count++;
        report_and_stop();
    end
    initial begin
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        t_por();
        t_expire();
        t_kick();
        t_glitch();
        t_disable();
        t_dip();
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
